// ### stage_seq.sv
/*
  Multistage speed sequencer: steps through 16 stages by time or terminal,
  applies the cycle mode, counts passes, keeps progress over power loss.
  Stage times are tenths of the selected unit and the time base restarts
  at every stage change, so a stage never runs short; a time of zero
  passes the stage in one clock.
  A stop records stage and frequency unless a power failure with retention
  off lands in the same clock and clears them; a power failure records
  them only while running with retention on, and clears them while retention is off.
  Assumes settings are stable levels from the parameter store and that
  step and power-fail inputs arrive asynchronously from terminals, while
  run_cmd comes from logic on this clock and is taken without synchroniser.
*/
// Behaviour
// - Cycle mode picks end-of-sequence behaviour
// - Stepping is automatic or by terminal
// - Power loss may keep stage and frequency
// - Start from first, saved stage, or frequency
// - Limited mode ends after programmed pass count
// - Stage time counted in seconds or minutes
// - Auto step when stage time expires
`timescale 1ns/1ns
`include "stage_seq_map.svh"

module stage_seq #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [1:0] cycle_mode, // End-of-sequence mode
  input wire logic manual_step, // 0 automatic, 1 terminal stepping
  input wire logic retain, // Keep progress over power loss
  input wire logic [1:0] start_mode, // Resume choice on start
  input wire logic [15:0] pass_limit, // Passes in limited mode
  input wire logic time_minutes, // Time unit select
  input wire logic [255:0] stage_time, // 16 x 16-bit tenths of unit
  input wire logic run_cmd, // Drive run command, level
  input wire logic step_pin, // Terminal step input, async
  input wire logic power_fail, // Power failure warning, async
  input wire logic [15:0] freq_in, // Present output frequency
  output logic [3:0] stage, // Active stage index
  output logic running, // Sequence active
  output logic stop_req, // Stop request to drive, level
  output logic done, // Sequence ended
  output logic [15:0] pass_count, // Completed passes
  output logic [3:0] saved_stage, // Stage stored at stop or loss
  output logic [15:0] saved_freq, // Frequency stored at stop or loss
  output logic resume_freq_valid // Apply saved frequency at resume
);
  stage_seq_pkg::seq_state_e state;
  stage_seq_pkg::seq_state_e next_state;
  logic [1:0] step_sync;
  logic [1:0] fail_sync;
  logic step_prev;
  logic fail_prev;
  logic run_prev;
  logic [15:0] elapsed;
  logic tick;
  logic [15:0] stage_len [0:`STAGE_COUNT-1];

  // Unpack stage time presets
  genvar gi;
  generate
    for (gi = 0; gi < `STAGE_COUNT; gi++) begin : g_len
      assign stage_len[gi] = stage_time[gi*16 +: 16];
    end
  endgenerate

  // Terminal and run command edges
  wire step_edge = step_sync[1] && !step_prev;
  wire fail_edge = fail_sync[1] && !fail_prev;
  wire start_edge = run_cmd && !run_prev;
  wire stop_edge = !run_cmd && run_prev;

  // Stage timing and advance; a saturated count still ends the longest stage
  wire in_run = (state == stage_seq_pkg::st_run);
  wire time_up = (elapsed >= stage_len[stage]) && (!tick || elapsed != 16'hFFFF);
  wire auto_adv = !manual_step && time_up && in_run;
  wire man_adv = manual_step && step_edge && in_run;
  wire advance = auto_adv || man_adv;
  wire last = (stage == `LAST_STAGE);
  wire pass_end = advance && last;

  // Time base restarts at each stage change so no stage starts mid-tenth
  wire tick_run = in_run && !manual_step && !advance;

  // Pass accounting and resume choice
  wire [15:0] passes_now = pass_count + 16'h0001;
  wire limit_hit = (passes_now >= pass_limit);
  wire resume = (start_mode != `START_FIRST);
  wire fresh = start_edge && !resume;

  // End-of-pass decision per cycle mode
  always_comb begin
    next_state = state;
    if (!run_cmd) begin
      next_state = stage_seq_pkg::st_idle;
    end else if (start_edge) begin
      next_state = stage_seq_pkg::st_run;
    end else if (pass_end) begin
      unique case (cycle_mode)
        `CYC_STOP_ONE: next_state = stage_seq_pkg::st_idle;
        `CYC_HOLD_LAST: next_state = stage_seq_pkg::st_hold;
        `CYC_LIMITED: next_state = limit_hit ? stage_seq_pkg::st_idle
                                             : stage_seq_pkg::st_run;
        `CYC_FOREVER: next_state = stage_seq_pkg::st_run;
      endcase
    end
  end

  tenth_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .resetn(resetn),
    .enable(tick_run),
    .minutes(time_minutes),
    .tick(tick)
  );

  // Input synchronisers and edge history
  always_ff @(posedge clk) begin
    if (!resetn) begin
      step_sync <= 2'h0;
      fail_sync <= 2'h0;
      step_prev <= 1'b0;
      fail_prev <= 1'b0;
    end else begin
      step_sync <= {step_sync[0], step_pin};
      fail_sync <= {fail_sync[0], power_fail};
      step_prev <= step_sync[1];
      fail_prev <= fail_sync[1];
    end
  end

  // Run command history; a level high out of reset counts as a start
  always_ff @(posedge clk) begin
    if (!resetn)
      run_prev <= 1'b0;
    else
      run_prev <= run_cmd;
  end

  // Sequencer state and stage index
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= stage_seq_pkg::st_idle;
      stage <= 4'h0;
      elapsed <= 16'h0000;
    end else begin
      state <= next_state;
      if (start_edge) begin
        stage <= resume ? saved_stage : 4'h0;
        elapsed <= 16'h0000;
      end else if (advance && !(last && cycle_mode == `CYC_HOLD_LAST)) begin
        stage <= last ? 4'h0 : stage + 4'h1;
        elapsed <= 16'h0000;
      end else if (tick && elapsed != 16'hFFFF) begin
        elapsed <= elapsed + 16'h0001;
      end
    end
  end

  // Pass counter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pass_count <= 16'h0000;
    end else if (fresh) begin
      pass_count <= 16'h0000;
    end else if (pass_end && pass_count != 16'hFFFF) begin
      pass_count <= passes_now;
    end
  end

  // Running and end-of-sequence flags
  always_ff @(posedge clk) begin
    if (!resetn) begin
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      running <= (next_state != stage_seq_pkg::st_idle);
      if (start_edge)
        done <= 1'b0;
      else if (pass_end && next_state != stage_seq_pkg::st_run)
        done <= 1'b1;
    end
  end

  // Stop request holds until the drive drops its run command
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stop_req <= 1'b0;
    end else if (pass_end && next_state == stage_seq_pkg::st_idle && run_cmd) begin
      stop_req <= 1'b1;
    end else if (!run_cmd) begin
      stop_req <= 1'b0;
    end
  end

  // Saved progress: on stop, or on power loss while running with retention on
  always_ff @(posedge clk) begin
    if (!resetn) begin
      saved_stage <= 4'h0;
      saved_freq <= 16'h0000;
    end else begin
      if (fail_edge && running && retain) begin
        saved_stage <= stage;
        saved_freq <= freq_in;
      end else if (fail_edge && !retain) begin
        saved_stage <= 4'h0;
        saved_freq <= 16'h0000;
      end else if (stop_edge) begin
        saved_stage <= stage;
        saved_freq <= freq_in;
      end
    end
  end

  // Frequency resume flag, live from a mode-2 start until the first advance or run command drop
  always_ff @(posedge clk) begin
    if (!resetn) begin
      resume_freq_valid <= 1'b0;
    end else if (start_edge) begin
      resume_freq_valid <= (start_mode == `START_STAGE_FREQ);
    end else if (advance || !run_cmd) begin
      resume_freq_valid <= 1'b0;
    end
  end
endmodule // stage_seq

// ### stage_seq_map.svh
/*
  Constants of the multistage speed sequencer: mode codes, reset values,
  stage count and time base counts.
  Assumes inclusion by bare name; no other dependencies.
*/
`ifndef STAGE_SEQ_MAP_SVH
`define STAGE_SEQ_MAP_SVH

// Cycle modes
`define CYC_STOP_ONE 2'h0
`define CYC_HOLD_LAST 2'h1
`define CYC_LIMITED 2'h2
`define CYC_FOREVER 2'h3
// Start modes
`define START_FIRST 2'h0
`define START_STAGE 2'h1
`define START_STAGE_FREQ 2'h2
// Stage layout
`define STAGE_COUNT 16
`define LAST_STAGE 4'hF
`define COUNT_RESET 16'h0001
// Time base: one tenth of a second at 100 MHz
`define CLK_HZ 100000000
`define TENTH_S_DIV 10
`define TICK_CYCLES (`CLK_HZ / `TENTH_S_DIV)
`define MIN_PER_S 60

`endif

// ### stage_seq_monitor.sv
/* Port checker of the stage sequencer.
   Assumes a bind onto stage_seq, one clock and reset. */
`timescale 1ns/1ns
module stage_seq_monitor #(parameter int unsigned TICK_CYCLES = 10) (
  input wire logic clk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [1:0] cycle_mode, // End-of-sequence mode
  input wire logic manual_step, // Terminal stepping
  input wire logic retain, // Retention over power loss
  input wire logic [1:0] start_mode, // Resume choice
  input wire logic [15:0] pass_limit, // Passes in limited mode
  input wire logic time_minutes, // Time unit
  input wire logic run_cmd, // Run command
  input wire logic [255:0] stage_time, // Stage time presets
  input wire logic step_pin, // Step terminal
  input wire logic power_fail, // Power failure warning
  input wire logic [3:0] stage, // Active stage
  input wire logic running, // Sequence active
  input wire logic stop_req, // Stop request
  input wire logic done, // Sequence ended
  input wire logic [15:0] pass_count, // Completed passes
  input wire logic [3:0] saved_stage, // Stored stage
  input wire logic resume_freq_valid // Frequency resume flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Start, end of sequence and resume
  property p_start; $rose(run_cmd) && !running && start_mode == 2'h0 |->
    ##[1:2] running && stage == 4'h0 && pass_count == 16'h0000; endproperty
  a_start: assert property (p_start) else $error("bad fresh start");
  property p_stop; cycle_mode == 2'h0 && $rose(done) |-> stop_req && !running; endproperty
  a_stop: assert property (p_stop) else $error("bad stop end");
  property p_hold; cycle_mode == 2'h1 && $rose(done) |-> running && !stop_req && stage == 4'hF;
  endproperty
  a_hold: assert property (p_hold) else $error("bad hold end");
  property p_limit; cycle_mode == 2'h2 && $rose(done) |-> pass_count == pass_limit; endproperty
  a_limit: assert property (p_limit) else $error("bad pass count");
  property p_resume; $rose(running) && start_mode == 2'h2 |->
    resume_freq_valid && stage == saved_stage; endproperty
  a_resume: assert property (p_resume) else $error("bad resume");
  // Stepping, retention and time base
  property p_manual; (manual_step && running && run_cmd && !step_pin)[*6] ##1 run_cmd |->
    $stable(stage); endproperty
  a_manual: assert property (p_manual) else $error("step without terminal");
  property p_noretain; $rose(power_fail) && !retain && !run_cmd && !running |->
    ##[3:6] saved_stage == 4'h0; endproperty
  a_noretain: assert property (p_noretain) else $error("stage kept");
  property p_minute; $rose(running) && time_minutes && !manual_step && stage == 4'h0 &&
    stage_time[15:0] == 16'h0001 |-> ##300 stage == 4'h0; endproperty
  a_minute: assert property (p_minute) else $error("minute base too fast");
endmodule // stage_seq_monitor

// ### stage_seq_pkg.sv
/*
  Types of the multistage speed sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package stage_seq_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_run = 2'h1,
    st_hold = 2'h2
  } seq_state_e;
endpackage

// ### tb_stage_seq.sv
/* Bench of the stage sequencer with a terminal model.
   Assumes TICK_CYCLES of 10 so stage times stay short. */
`timescale 1ns/1ns
module tb_stage_seq;
  logic clk, resetn, manual_step, retain, time_minutes, run_cmd, step_pin, power_fail;
  logic running, stop_req, done, resume_freq_valid;
  logic [1:0] cycle_mode, start_mode;
  logic [3:0] stage, saved_stage;
  logic [15:0] pass_limit, freq_in, pass_count, saved_freq;
  logic [255:0] stage_time;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  stage_seq #(.TICK_CYCLES(10)) i_stage_seq (
    .clk(clk),
    .resetn(resetn),
    .cycle_mode(cycle_mode),
    .manual_step(manual_step),
    .retain(retain),
    .start_mode(start_mode),
    .pass_limit(pass_limit),
    .time_minutes(time_minutes),
    .stage_time(stage_time),
    .run_cmd(run_cmd),
    .step_pin(step_pin),
    .power_fail(power_fail),
    .freq_in(freq_in),
    .stage(stage),
    .running(running),
    .stop_req(stop_req),
    .done(done),
    .pass_count(pass_count),
    .saved_stage(saved_stage),
    .saved_freq(saved_freq),
    .resume_freq_valid(resume_freq_valid)
  );
  term_model i_term (
    .clk(clk),
    .step_pin(step_pin),
    .power_fail(power_fail)
  );
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (++cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Stop, set modes, start again
  task automatic go(input logic [1:0] cm, input logic [1:0] sm);
    run_cmd = 1'b0;
    ticks(3);
    {cycle_mode, start_mode, run_cmd} = {cm, sm, 1'b1};
    ticks(4);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 600 && done !== 1'b1; i++) ticks(1);
    if (done !== 1'b1) begin
      failures++;
      $display("ERROR t=%0t done wait ran out got=%h exp=%h", $time, done, 1'b1);
      end_sim();
    end
  endtask
  // Main sequence
  initial begin
    {resetn, manual_step, retain, time_minutes, run_cmd, cycle_mode, start_mode} = 9'h000;
    {pass_limit, freq_in, stage_time} = {16'h0003, 16'h1234, 256'h0};
    ticks(8);
    resetn = 1'b1;
    go(2'h0, 2'h0);
    wait_done();
    chk({14'h0, stop_req, running}, 16'h0002);
    chk(pass_count, 16'h0001);
    go(2'h2, 2'h0);
    wait_done();
    chk(pass_count, 16'h0003);
    go(2'h1, 2'h0);
    wait_done();
    chk({11'h0, running, stage}, 16'h001F);
    go(2'h3, 2'h0);
    ticks(200);
    chk({15'h0, done}, 16'h0000);
    // Terminal stepping, retention and resume
    manual_step = 1'b1;
    go(2'h3, 2'h0);
    repeat (3) i_term.press(1'b0);
    chk({12'h0, stage}, 16'h0003);
    {retain, freq_in} = {1'b1, 16'h0ABC};
    i_term.press(1'b1);
    chk({12'h0, saved_stage}, 16'h0003);
    chk(saved_freq, 16'h0ABC);
    freq_in = 16'h1234;
    go(2'h3, 2'h1);
    chk({12'h0, stage}, 16'h0003);
    go(2'h3, 2'h2);
    chk({11'h0, resume_freq_valid, stage}, 16'h0013);
    chk(saved_freq, 16'h1234);
    {run_cmd, retain} = 2'h0;
    ticks(3);
    i_term.press(1'b1);
    chk({12'h0, saved_stage}, 16'h0000);
    // Minute base holds stage 0, second base runs through
    {manual_step, time_minutes, stage_time[15:0]} = {2'h1, 16'h0001};
    go(2'h1, 2'h0);
    ticks(400);
    chk({12'h0, stage}, 16'h0000);
    time_minutes = 1'b0;
    go(2'h1, 2'h0);
    chk({12'h0, stage}, 16'h0000);
    ticks(100);
    chk({12'h0, stage}, 16'h000F);
    end_sim();
  end
endmodule // tb_stage_seq
bind stage_seq stage_seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (
  .clk(clk),
  .resetn(resetn),
  .cycle_mode(cycle_mode),
  .manual_step(manual_step),
  .retain(retain),
  .start_mode(start_mode),
  .pass_limit(pass_limit),
  .time_minutes(time_minutes),
  .run_cmd(run_cmd),
  .stage_time(stage_time),
  .step_pin(step_pin),
  .power_fail(power_fail),
  .stage(stage),
  .running(running),
  .stop_req(stop_req),
  .done(done),
  .pass_count(pass_count),
  .saved_stage(saved_stage),
  .resume_freq_valid(resume_freq_valid)
);

// ### tenth_tick.sv
/*
  Tenth-of-unit tick generator: one-cycle pulse every tenth of a second
  or tenth of a minute while enabled.
  Assumes clk at 100 MHz and synchronous active-low reset.
*/
`timescale 1ns/1ns
`include "stage_seq_map.svh"

module tenth_tick #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic enable, // Count only while high
  input wire logic minutes, // Time unit: 0 seconds, 1 minutes
  output logic tick // Pulse per tenth of unit
);
  logic [26:0] sub;
  logic [5:0] mult;
  wire sub_end = (sub == 27'(TICK_CYCLES - 1));
  wire mult_end = minutes ? (mult == 6'(`MIN_PER_S - 1)) : 1'b1;

  // Prescaler and minute multiplier
  always_ff @(posedge clk) begin
    if (!resetn || !enable) begin
      sub <= 27'h0000000;
      mult <= 6'h00;
      tick <= 1'b0;
    end else begin
      tick <= sub_end && mult_end;
      sub <= sub_end ? 27'h0000000 : sub + 27'h0000001;
      if (sub_end)
        mult <= mult_end ? 6'h00 : mult + 6'h01;
    end
  end
endmodule // tenth_tick

// ### term_model.sv
/* Terminal model: step and power-fail inputs as held pulses.
   Assumes the bench calls press between its own actions. */
`timescale 1ns/1ns
module term_model (
  input wire logic clk, // System clock
  output logic step_pin, // Step terminal
  output logic power_fail // Power failure warning
);
  // Idle low between presses
  initial {step_pin, power_fail} = 2'h0;
  // Pulse outlasting the synchroniser, then a gap
  task automatic press(input bit fail);
    @(posedge clk);
    #1 {power_fail, step_pin} = fail ? 2'h2 : 2'h1;
    repeat (4) @(posedge clk);
    #1 {step_pin, power_fail} = 2'h0;
    repeat (4) @(posedge clk);
  endtask
endmodule // term_model
